// ### core/ddrpi_pkg.sv
// Shared constants and carrier types of the DRAM pin interface
package ddrpi_pkg;
   // ************************************************
   // Widths and timing
   // ************************************************
   localparam int ADDR_W   = 20;
   localparam int BANK_W   = 4;
   localparam int DATA_W   = 36;
   localparam int NUM_DK   = 2;
   localparam int NUM_QK   = 4;
   localparam int CFG_W    = ADDR_W + BANK_W;
   localparam int COL_W    = 3;
   localparam int MEM_IW   = BANK_W + COL_W;
   localparam int MEM_WORDS = 1 << MEM_IW;
   localparam int RD_LAT   = 3;
   localparam int MIR_BIT  = 5;
   localparam int REF_CNT_W = 16;

   // ************************************************
   // Data groups per write and read strobe clock
   // ************************************************
   localparam logic [DATA_W-1:0] GRP_DK0 = 36'h007fc01ff;
   localparam logic [DATA_W-1:0] GRP_DK1 = 36'hff803fe00;
   localparam logic [DATA_W-1:0] GRP_QK0 = 36'h0000001ff;
   localparam logic [DATA_W-1:0] GRP_QK1 = 36'h00003fe00;
   localparam logic [DATA_W-1:0] GRP_QK2 = 36'h0007c0000 | 36'h000800000 | 36'h007000000;
   localparam logic [DATA_W-1:0] GRP_QK3 = 36'hff8000000;

   // ************************************************
   // Carrier types
   // ************************************************
   typedef struct packed {
      logic                chip_select_n;
      logic                write_cmd_n;
      logic                refresh_cmd_n;
      logic [BANK_W-1:0]   bank;
      logic [ADDR_W-1:0]   addr;
   } ddrpi_pins_t;

   typedef struct packed {
      logic                cfg;
      logic                wr;
      logic                rd;
      logic                rf;
      logic [BANK_W-1:0]   bank;
      logic [ADDR_W-1:0]   addr;
   } ddrpi_cmd_t;

   localparam ddrpi_pins_t PINS_IDLE = 27'h7000000;
endpackage

// ### core/ddrpi_core.sv
// Device-side pin interface: command decode, DDR write capture, DDR read return
// Functional notes
// - Address taken at main clock rising edge
// - Config load takes address plus bank bits
// - Reads and writes go to their selected bank
// - Commands latched only on true clock rise
// - Chip select high ignores new commands
// - Command from write, refresh, chip select
// - Read words on both read strobe edges
// - Write words sampled on both strobe edges
// - Wide part strobe groups split data bits
// - Narrow part uses strobe groups 0, 1
// - Masked group bits are not stored
// - Mask bits cover their strobe groups
// - Read strobes free-running, edge-aligned with data
// - Four read strobes, each one data group
// - Valid flag one clock before data
// - Two valid flags, lower and upper half
// - Reset acts without any clock
// - Mirror select moves address, command positions
// - Spare select position mirrors address bit 5
module ddrpi_core
   import ddrpi_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                ck,
   input  wire ddrpi_pins_t         cmd_pins,
   input  wire logic                spare_select_pin,
   input  wire logic                mirror_select,
   input  wire logic [NUM_DK-1:0]   write_strobe_clock,
   input  wire logic [1:0]          write_byte_mask,
   input  wire logic [DATA_W-1:0]   dq_i,
   output logic      [DATA_W-1:0]   dq_o,
   output logic      [DATA_W-1:0]   dq_oe,
   output logic      [NUM_QK-1:0]   read_strobe_clock,
   output logic      [NUM_QK-1:0]   read_strobe_clock_n,
   output logic      [1:0]          read_valid_flag,
   output logic      [CFG_W-1:0]    config_value,
   output logic      [REF_CNT_W-1:0] refresh_count
);

   // ************************************************
   // Reset release
   // ************************************************
   logic [1:0] rst_sync_ff;
   logic       rst_int_n;

   // Assert at once, release after two edges
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_int_n = rst_sync_ff[1];

   // ************************************************
   // Pin synchronisers
   // ************************************************
   localparam int MISC_W = 1 + 1 + 1 + NUM_DK + 2 + DATA_W;

   ddrpi_pins_t        pins_s1_ff;
   ddrpi_pins_t        pins_s2_ff;
   logic [MISC_W-1:0]  misc_s1_ff;
   logic [MISC_W-1:0]  misc_s2_ff;
   logic               ck_d3_ff;
   logic [NUM_DK-1:0]  dk_d3_ff;
   logic               ck_s2;
   logic               spare_s2;
   logic               mirror_s2;
   logic [NUM_DK-1:0]  dk_s2;
   logic [1:0]         mask_s2;
   logic [DATA_W-1:0]  dq_s2;
   logic               ck_rise;
   logic               ck_fall;
   logic [NUM_DK-1:0]  dk_rise;
   logic [NUM_DK-1:0]  dk_fall;

   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         pins_s1_ff <= PINS_IDLE;
         pins_s2_ff <= PINS_IDLE;
         misc_s1_ff <= '0;
         misc_s2_ff <= '0;
         ck_d3_ff   <= 1'b0;
         dk_d3_ff   <= '0;
      end
      else
      begin
         pins_s1_ff <= cmd_pins;
         pins_s2_ff <= pins_s1_ff;
         misc_s1_ff <= {ck, spare_select_pin, mirror_select, write_strobe_clock, write_byte_mask, dq_i};
         misc_s2_ff <= misc_s1_ff;
         ck_d3_ff   <= ck_s2;
         dk_d3_ff   <= dk_s2;
      end
   end

   assign {ck_s2, spare_s2, mirror_s2, dk_s2, mask_s2, dq_s2} = misc_s2_ff;
   // Only the true phase is watched; the complement carries no extra timing here
   assign ck_rise = ck_s2 & ~ck_d3_ff;
   assign ck_fall = ~ck_s2 & ck_d3_ff;
   assign dk_rise = dk_s2 & ~dk_d3_ff;
   assign dk_fall = ~dk_s2 & dk_d3_ff;

   // ************************************************
   // Mirror layout and command decode
   // ************************************************
   logic [ADDR_W-1:0] addr_l;
   logic [BANK_W-1:0] bank_l;
   logic              we_l_n;
   logic              ref_l_n;
   ddrpi_cmd_t        cmd;

   always_comb
   begin
      addr_l  = pins_s2_ff.addr;
      bank_l  = pins_s2_ff.bank;
      we_l_n  = pins_s2_ff.write_cmd_n;
      ref_l_n = pins_s2_ff.refresh_cmd_n;
      if (mirror_s2)
      begin
         // Mirrored board: balls swap sides, so the buses arrive reversed
         addr_l  = {<<{pins_s2_ff.addr}};
         bank_l  = {<<{pins_s2_ff.bank}};
         we_l_n  = pins_s2_ff.refresh_cmd_n;
         ref_l_n = pins_s2_ff.write_cmd_n;
         addr_l[MIR_BIT] = spare_s2;
      end
   end

   always_comb
   begin
      cmd      = '0;
      cmd.bank = bank_l;
      cmd.addr = addr_l;
      if (ck_rise && !pins_s2_ff.chip_select_n)
      begin
         cmd.cfg = !we_l_n && !ref_l_n;
         cmd.wr  = !we_l_n && ref_l_n;
         cmd.rf  = we_l_n && !ref_l_n;
         cmd.rd  = we_l_n && ref_l_n;
      end
   end

   // ************************************************
   // Configuration and refresh state
   // ************************************************
   logic [CFG_W-1:0]     cfg_ff;
   logic [REF_CNT_W-1:0] ref_cnt_ff;

   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
         cfg_ff <= '0;
      else if (cmd.cfg)
         cfg_ff <= {cmd.bank, cmd.addr};
   end

   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
         ref_cnt_ff <= '0;
      else if (cmd.rf)
         ref_cnt_ff <= ref_cnt_ff + 16'h0001;
   end

   assign config_value  = cfg_ff;
   assign refresh_count = ref_cnt_ff;

   // ************************************************
   // Write capture, one tracker per strobe group
   // ************************************************
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [MEM_IW-2:0] wr_idx_ff;
   logic [NUM_DK-1:0] wr_pend_ff;
   logic [NUM_DK-1:0] wr_second_ff;
   logic [DATA_W-1:0] wmask0;
   logic [DATA_W-1:0] wmask1;
   logic [DATA_W-1:0] grp_bits [NUM_DK];

   assign grp_bits[0] = GRP_DK0;
   assign grp_bits[1] = GRP_DK1;

   // A new write command restarts both trackers; an unfinished burst is dropped
   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         wr_idx_ff    <= '0;
         wr_pend_ff   <= '0;
         wr_second_ff <= '0;
      end
      else if (cmd.wr)
      begin
         wr_idx_ff    <= {cmd.bank, cmd.addr[COL_W-1:1]};
         wr_pend_ff   <= '1;
         wr_second_ff <= '0;
      end
      else
      begin
         for (int g = 0; g < NUM_DK; g++)
         begin
            if (wr_pend_ff[g] && !wr_second_ff[g] && dk_rise[g])
               wr_second_ff[g] <= 1'b1;
            else if (wr_pend_ff[g] && wr_second_ff[g] && dk_fall[g])
            begin
               wr_pend_ff[g]   <= 1'b0;
               wr_second_ff[g] <= 1'b0;
            end
         end
      end
   end

   always_comb
   begin
      wmask0 = '0;
      wmask1 = '0;
      for (int g = 0; g < NUM_DK; g++)
      begin
         if (!cmd.wr && wr_pend_ff[g] && !mask_s2[g])
         begin
            if (!wr_second_ff[g] && dk_rise[g])
               wmask0 = wmask0 | grp_bits[g];
            if (wr_second_ff[g] && dk_fall[g])
               wmask1 = wmask1 | grp_bits[g];
         end
      end
   end

   // Storage carries no reset; contents are undefined until written
   always_ff @(posedge clk_sys)
   begin
      if (|wmask0)
         mem[{wr_idx_ff, 1'b0}] <= (mem[{wr_idx_ff, 1'b0}] & ~wmask0) | (dq_s2 & wmask0);
      if (|wmask1)
         mem[{wr_idx_ff, 1'b1}] <= (mem[{wr_idx_ff, 1'b1}] & ~wmask1) | (dq_s2 & wmask1);
   end

   // ************************************************
   // Read pipeline and data return
   // ************************************************
   logic [RD_LAT-1:0] rd_pipe_ff;
   logic [MEM_IW-2:0] rd_idx_ff [RD_LAT];
   logic [MEM_IW-2:0] rd_cur_ff;
   logic              rd_second_ff;
   logic              valid_ff;
   logic [DATA_W-1:0] dq_o_ff;
   logic              oe_ff;
   logic [NUM_QK-1:0] qk_ff;
   logic [NUM_QK-1:0] qk_n_ff;

   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         rd_pipe_ff <= '0;
         for (int i = 0; i < RD_LAT; i++)
            rd_idx_ff[i] <= '0;
      end
      else if (ck_rise)
      begin
         rd_pipe_ff   <= {rd_pipe_ff[RD_LAT-2:0], cmd.rd};
         rd_idx_ff[0] <= {cmd.bank, cmd.addr[COL_W-1:1]};
         for (int i = 1; i < RD_LAT; i++)
            rd_idx_ff[i] <= rd_idx_ff[i-1];
      end
   end

   // Flag rises one clock ahead of the first data word
   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
         valid_ff <= 1'b0;
      else if (ck_rise)
         valid_ff <= rd_pipe_ff[RD_LAT-2];
   end

   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         dq_o_ff      <= '0;
         oe_ff        <= 1'b0;
         rd_second_ff <= 1'b0;
         rd_cur_ff    <= '0;
      end
      else if (ck_rise)
      begin
         rd_second_ff <= rd_pipe_ff[RD_LAT-1];
         oe_ff        <= rd_pipe_ff[RD_LAT-1];
         rd_cur_ff    <= rd_idx_ff[RD_LAT-1];
         if (rd_pipe_ff[RD_LAT-1])
            dq_o_ff <= mem[{rd_idx_ff[RD_LAT-1], 1'b0}];
      end
      else if (ck_fall && rd_second_ff)
      begin
         dq_o_ff      <= mem[{rd_cur_ff, 1'b1}];
         rd_second_ff <= 1'b0;
      end
   end

   // Strobes follow the clock in the same cycle as data changes
   always_ff @(posedge clk_sys or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         qk_ff   <= '0;
         qk_n_ff <= '1;
      end
      else
      begin
         qk_ff   <= {NUM_QK{ck_s2}};
         qk_n_ff <= {NUM_QK{~ck_s2}};
      end
   end

   assign dq_o                = dq_o_ff;
   assign dq_oe               = {DATA_W{oe_ff}};
   assign read_strobe_clock   = qk_ff;
   assign read_strobe_clock_n = qk_n_ff;
   assign read_valid_flag     = {2{valid_ff}};

endmodule

// ### bench/ddrpi_assertions.sv
// Port-level checks of the DRAM pin interface
module ddrpi_assertions
   import ddrpi_pkg::*;
(
   input wire logic                 clk_sys,
   input wire logic                 rst_n,
   input wire logic                 ck,
   input wire logic [DATA_W-1:0]    dq_o,
   input wire logic [DATA_W-1:0]    dq_oe,
   input wire logic [NUM_QK-1:0]    read_strobe_clock,
   input wire logic [NUM_QK-1:0]    read_strobe_clock_n,
   input wire logic [1:0]           read_valid_flag,
   input wire logic [CFG_W-1:0]     config_value,
   input wire logic [REF_CNT_W-1:0] refresh_count
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence s_flag;
      $rose(read_valid_flag[0]);
   endsequence
   sequence s_burst;
      $rose(dq_oe[0]) && $rose(read_strobe_clock[0]);
   endsequence
   // One ck period is 12.8 clk_sys cycles
   a_flag_leads: assert property (s_flag |-> ##[11:14] s_burst)
      else $error("read data late after valid flag");
   a_flag_first: assert property ($rose(dq_oe[0]) |-> $past(read_valid_flag[0]))
      else $error("read data without valid flag");
   a_word_edge: assert property (dq_oe[0] && $past(dq_oe[0]) && $changed(dq_o)
      |-> $changed(read_strobe_clock[0])) else $error("read word moved off strobe edge");
   a_strobe_pair: assert property (read_strobe_clock_n == ~read_strobe_clock)
      else $error("read strobes not complementary");
   a_group_copy: assert property (read_strobe_clock == {NUM_QK{read_strobe_clock[0]}}
      && dq_oe == {DATA_W{dq_oe[0]}}) else $error("groups disagree");
   a_flag_halves: assert property (read_valid_flag[1] == read_valid_flag[0])
      else $error("valid flags disagree");
   a_strobe_runs: assert property ($rose(ck) |-> ##[2:6] read_strobe_clock[0])
      else $error("read strobe not following clock");
   a_refresh_step: assert property ($changed(refresh_count)
      |-> refresh_count == $past(refresh_count) + 16'h1) else $error("refresh count jump");
   a_cfg_on_ck: assert property ($changed(config_value) |-> ck)
      else $error("config changed off clock rise");
   a_reset_clear: assert property (disable iff (1'h0) !rst_n
      |-> dq_oe == '0 && config_value == '0) else $error("outputs live in reset");
endmodule
bind ddrpi_core ddrpi_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .ck(ck), .dq_o(dq_o),
   .dq_oe(dq_oe), .read_strobe_clock(read_strobe_clock), .read_strobe_clock_n(read_strobe_clock_n),
   .read_valid_flag(read_valid_flag), .config_value(config_value), .refresh_count(refresh_count));

// ### bench/ddrpi_ctrl_model.sv
// Memory controller model on the far side of the pins
module ddrpi_ctrl_model
   import ddrpi_pkg::*;
(
   output logic              ck,
   output ddrpi_pins_t       cmd_pins,
   output logic [NUM_DK-1:0] write_strobe_clock,
   output logic [1:0]        write_byte_mask,
   output logic [DATA_W-1:0] dq_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      cmd_pins = PINS_IDLE;
      write_byte_mask = 2'h0;
      dq_i = '0;
      write_strobe_clock = 2'h0;
      // Offset keeps strobe edges clear of ck edges
      #16;
      forever #64 write_strobe_clock = ~write_strobe_clock;
   end
   // Single owner of the link clock
   initial
   begin
      ck = 1'h0;
      forever #32 ck = ~ck;
   end
   // Pins set on ck fall, held over the rise
   task automatic cmd(input ddrpi_pins_t p);
      @(negedge ck);
      cmd_pins <= p;
      @(negedge ck);
      // Inverted address so a stale value never passes
      cmd_pins <= {3'h7, ~p.bank, ~p.addr};
   endtask
   task automatic wr(input logic cs_n, input logic [3:0] bk, input logic [19:0] a,
                     input logic [35:0] w0, w1, input logic [1:0] m0, m1);
      dq_i <= w0;
      write_byte_mask <= m0;
      cmd({cs_n, 2'h1, bk, a});
      @(posedge write_strobe_clock[0]);
      #32 dq_i <= w1;
      write_byte_mask <= m1;
      @(negedge write_strobe_clock[0]);
      #32 dq_i <= ~w1;
      write_byte_mask <= ~m1;
      // Gap so a following call never reassigns data in the same step
      @(negedge ck);
   endtask
endmodule

// ### bench/ddrpi_core_tb_top.sv
// Self-checking bench of the DRAM pin interface
module ddrpi_core_tb_top
   import ddrpi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [35:0] W0 = 36'h123456789;
   localparam logic [35:0] W1 = 36'hfedcba987;
   localparam logic [35:0] N0 = 36'h5a5a5a5a5;
   localparam logic [35:0] N1 = 36'h0f0f0f0f0;
   localparam logic [35:0] E0 = (W0 & GRP_DK0) | (N0 & GRP_DK1);
   localparam logic [35:0] E1 = (W1 & GRP_DK1) | (N1 & GRP_DK0);
   logic             clk_sys = 1'h0;
   logic             rst_n = 1'h1;
   logic             spare = 1'h0;
   logic             mirror = 1'h0;
   logic             ck;
   ddrpi_pins_t      pins;
   logic [1:0]       dk;
   logic [1:0]       dm;
   logic [35:0]      dq_drv;
   logic [35:0]      dq_o;
   logic [35:0]      dq_oe;
   logic [3:0]       qk;
   logic [1:0]       vld;
   logic [23:0]      cfg;
   logic [15:0]      rcnt;
   int               miscompares = 0;
   int               comparisons = 0;
   wire logic [35:0] dq_bus = (dq_oe & dq_o) | (~dq_oe & dq_drv);
   always #2.5 clk_sys = ~clk_sys;
   ddrpi_ctrl_model ctl (.ck(ck), .cmd_pins(pins), .write_strobe_clock(dk), .write_byte_mask(dm),
      .dq_i(dq_drv));
   ddrpi_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .ck(ck), .cmd_pins(pins), .spare_select_pin(spare),
      .mirror_select(mirror), .write_strobe_clock(dk), .write_byte_mask(dm), .dq_i(dq_bus),
      .dq_o(dq_o), .dq_oe(dq_oe), .read_strobe_clock(qk), .read_strobe_clock_n(),
      .read_valid_flag(vld), .config_value(cfg), .refresh_count(rcnt));
   task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   function automatic logic [19:0] rev20(input logic [19:0] v);
      for (int i = 0; i < 20; i++)
         rev20[i] = v[19 - i];
   endfunction
   task automatic rd(input logic [3:0] bk, input logic [19:0] a, input logic [35:0] e0, e1);
      int n;
      n = 0;
      ctl.cmd({3'h3, bk, a});
      while (vld !== 2'h3 && n < 80)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk("vld", 36'(vld), 36'h3);
      n = 0;
      while (dq_oe[0] !== 1'h1 && n < 20)
      begin
         @(negedge clk_sys);
         n++;
      end
      // Flag leads data by one ck period, 12.8 system cycles
      chk("lead", 36'(n >= 12 && n <= 13), 36'h1);
      chk("oe", dq_oe, '1);
      chk("vld drop", 36'(vld), 36'h0);
      chk("qk rise", 36'(qk), 36'hf);
      chk("word0", dq_o, e0);
      // Word 1 sits half a ck period later
      repeat (9) @(negedge clk_sys);
      chk("qk fall", 36'(qk), 36'h0);
      chk("word1", dq_o, e1);
      repeat (20) @(negedge clk_sys);
   endtask
   task automatic t_cmds();
      logic [15:0] n;
      n = rcnt;
      ctl.cmd({3'h0, 4'ha, 20'h5a5c3});
      @(negedge clk_sys);
      chk("cfg", 36'(cfg), 36'ha5a5c3);
      ctl.cmd({3'h4, 4'h1, 20'h11111});
      ctl.cmd({3'h2, 4'h2, 20'h0});
      ctl.cmd({3'h2, 4'h3, 20'h0});
      ctl.cmd({3'h6, 4'h4, 20'h0});
      @(negedge clk_sys);
      chk("cfg desel", 36'(cfg), 36'ha5a5c3);
      chk("refresh", 36'(rcnt), 36'(n + 16'h2));
      $display("command test done");
   endtask
   task automatic t_data();
      ctl.wr(1'h0, 4'h5, 20'h3, W0, W1, 2'h0, 2'h0);
      rd(4'h5, 20'h2, W0, W1);
      ctl.wr(1'h0, 4'h5, 20'h2, N0, N1, 2'h1, 2'h2);
      ctl.wr(1'h1, 4'h5, 20'h2, N1, N0, 2'h0, 2'h0);
      ctl.wr(1'h0, 4'h6, 20'h2, N1, N0, 2'h0, 2'h0);
      rd(4'h5, 20'h3, E0, E1);
      rd(4'h6, 20'h2, N1, N0);
      $display("data test done");
   endtask
   task automatic t_mirror();
      logic [15:0] n;
      @(posedge clk_sys);
      mirror <= 1'h1;
      spare <= 1'h1;
      repeat (8) @(posedge clk_sys);
      n = rcnt;
      ctl.cmd({3'h0, 4'hc, rev20(20'h12345)});
      ctl.cmd({3'h1, 4'h0, 20'h0});
      @(negedge clk_sys);
      chk("mir cfg", 36'(cfg), 36'h312365);
      chk("mir ref", 36'(rcnt), 36'(n + 16'h1));
      @(posedge clk_sys);
      mirror <= 1'h0;
      spare <= 1'h0;
      repeat (8) @(posedge clk_sys);
      $display("mirror test done");
   endtask
   task automatic t_reset();
      @(posedge clk_sys);
      rst_n <= 1'h0;
      #1;
      chk("rst cfg", 36'(cfg), 36'h0);
      chk("rst ref", 36'(rcnt), 36'h0);
      chk("rst oe", dq_oe, 36'h0);
      chk("rst vld", 36'(vld), 36'h0);
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (30) @(posedge clk_sys);
      ctl.cmd({3'h0, 4'h7, 20'h1});
      @(negedge clk_sys);
      chk("cfg again", 36'(cfg), 36'h700001);
      $display("reset test done");
   endtask
   initial
   begin
      // Reset edge at time zero so no output starts unknown
      rst_n <= 1'h0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (30) @(posedge clk_sys);
      t_cmds();
      t_data();
      t_mirror();
      t_reset();
      tally_and_finish();
   end
   // Whole run needs about 4 us
   initial
   begin
      #60000;
      miscompares++;
      tally_and_finish();
   end
endmodule
